// ==== hdl/nac_ctrl.sv ====
// Purpose: APB register file and sequencer for flash and eeprom self-programming
// Assumes: array samples strobes on pclk; read data valid the cycle after the read strobe
// Notes: one APB wait state on every transfer; all outputs are flip-flops
//
// Decided for this implementation: the APB register port and the register offsets.
module nac_ctrl #(
  parameter int PROG_CYCLES = nac_pkg::PROG_CYCLES,
  parameter int CNT_W       = 18
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_rd_en,
  output logic             mem_erase_en,
  output logic             mem_wr_en,
  output logic             mem_flash,
  output logic             mem_cfg,
  output logic      [14:0] mem_addr,
  output logic      [13:0] mem_wdata,
  input  wire logic [13:0] mem_rdata,
  output logic             cpu_stall
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
    $error("PROG_CYCLES does not fit the cycle counter");
  end

  typedef enum logic [2:0] {
    RID_DLO, RID_DHI, RID_ALO, RID_AHI, RID_CTL, RID_KEY, RID_NONE
  } nac_rid_t;

  typedef struct packed {
    nac_pkg::nac_state_t                            st;
    logic                                           mem_sel;
    logic                                           cfg_sel;
    logic                                           llo;
    logic                                           erase_sel;
    logic                                           err;
    logic                                           pen;
    logic                                           wr;
    logic                                           rd;
    logic                                           op_flash;
    logic                                           op_erase;
    logic [7:0]                                     data_lo;
    logic [5:0]                                     data_hi;
    logic [7:0]                                     adr_lo;
    logic [6:0]                                     adr_hi;
    logic [1:0]                                     key;
    logic [nac_pkg::LATCH_COUNT-1:0][13:0]          latch;
    logic [nac_pkg::LATCH_W-1:0]                    idx;
    logic [CNT_W-1:0]                               cnt;
    logic                                           pready;
    logic                                           pslverr;
    logic [31:0]                                    prdata;
    logic                                           mem_rd;
    logic                                           mem_erase;
    logic                                           mem_wr;
    logic                                           mem_flash;
    logic                                           mem_cfg;
    logic [14:0]                                    mem_addr;
    logic [13:0]                                    mem_wdata;
    logic                                           stall;
  } nac_regs_t;

  nac_regs_t s_r;
  nac_regs_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // register id from a byte address
  function automatic nac_rid_t reg_id(input logic [7:0] a);
    if (a == nac_pkg::OFF_DATA_LO) begin
      return RID_DLO;
    end else if (a == nac_pkg::OFF_DATA_HI) begin
      return RID_DHI;
    end else if (a == nac_pkg::OFF_ADR_LO) begin
      return RID_ALO;
    end else if (a == nac_pkg::OFF_ADR_HI) begin
      return RID_AHI;
    end else if (a == nac_pkg::OFF_CTL) begin
      return RID_CTL;
    end else if (a == nac_pkg::OFF_KEY) begin
      return RID_KEY;
    end else begin
      return RID_NONE;
    end
  endfunction : reg_id

  // config space permission; a write may start only at a user id
  function automatic logic cfg_ok(input logic [14:0] a, input logic is_wr);
    logic [15:0] f;
    logic        uid;
    logic        ro;
    f   = {1'b1, a};
    uid = (f >= nac_pkg::CFG_UID_FIRST) && (f <= nac_pkg::CFG_UID_LAST);
    ro  = (f == nac_pkg::CFG_DEVID) ||
          ((f >= nac_pkg::CFG_WORD_FIRST) && (f <= nac_pkg::CFG_WORD_LAST));
    return is_wr ? uid : (uid | ro);
  endfunction : cfg_ok

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  logic [14:0] adr;
  logic        bus_acc;
  nac_rid_t    rid;
  assign adr     = {s_r.adr_hi, s_r.adr_lo};
  assign bus_acc = psel && penable && s_r.pready;
  assign rid     = reg_id(paddr);

  always_comb begin
    logic [7:0] ctl_rd;
    logic       flash_new;
    logic       go_ok;
    ctl_rd    = {s_r.mem_sel, s_r.cfg_sel, s_r.llo, s_r.erase_sel,
                 s_r.err, s_r.pen, s_r.wr, s_r.rd};
    flash_new = 1'b0;
    go_ok     = 1'b0;
    s_nxt     = s_r;
    s_nxt.pready    = 1'b0;
    s_nxt.pslverr   = 1'b0;
    s_nxt.mem_rd    = 1'b0;
    s_nxt.mem_erase = 1'b0;
    s_nxt.mem_wr    = 1'b0;

    // apb access phase: answer after one wait state
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = (rid == RID_NONE);
      s_nxt.prdata  = 32'h0000_0000;
      case (rid)
        RID_DLO: s_nxt.prdata[7:0] = s_r.data_lo;
        RID_DHI: s_nxt.prdata[7:0] = {2'b00, s_r.data_hi};
        RID_ALO: s_nxt.prdata[7:0] = s_r.adr_lo;
        RID_AHI: s_nxt.prdata[7:0] = {1'b1, s_r.adr_hi};
        RID_CTL: s_nxt.prdata[7:0] = ctl_rd;
        default: s_nxt.prdata      = 32'h0000_0000;
      endcase
    end

    // sequencer
    case (s_r.st)
      nac_pkg::ST_READ: begin
        if (s_r.cfg_sel && !cfg_ok(adr, 1'b0)) begin
          s_nxt.data_lo = nac_pkg::DATA_RST;
          s_nxt.data_hi = nac_pkg::DATA_RST[5:0];
          s_nxt.rd      = 1'b0;
          s_nxt.st      = nac_pkg::ST_IDLE;
        end else begin
          s_nxt.mem_rd    = 1'b1;
          s_nxt.mem_addr  = adr;
          s_nxt.mem_cfg   = s_r.cfg_sel;
          s_nxt.mem_flash = s_r.mem_sel | s_r.cfg_sel;
          s_nxt.st        = nac_pkg::ST_RCAP;
        end
      end
      nac_pkg::ST_RCAP: begin
        // data arrives the cycle after the strobe
        if (!s_r.mem_rd) begin
          s_nxt.data_lo = mem_rdata[7:0];
          if (s_r.mem_flash) begin
            s_nxt.data_hi = mem_rdata[13:8];
          end
          s_nxt.rd = 1'b0;
          s_nxt.st = nac_pkg::ST_IDLE;
        end
      end
      nac_pkg::ST_ERASE: begin
        s_nxt.mem_erase = 1'b1;
        s_nxt.mem_addr  = s_r.op_flash ? {adr[14:5], 5'h00} : adr;
        // eeprom always follows its erase with a write
        s_nxt.st = s_r.op_flash ? nac_pkg::ST_WAIT : nac_pkg::ST_STREAM;
      end
      nac_pkg::ST_STREAM: begin
        s_nxt.mem_wr = 1'b1;
        if (s_r.op_flash) begin
          // whole latch block goes out, loaded or not
          s_nxt.mem_addr  = {adr[14:5], s_r.idx};
          s_nxt.mem_wdata = s_r.latch[s_r.idx];
        end else begin
          s_nxt.mem_addr  = adr;
          s_nxt.mem_wdata = {6'h00, s_r.data_lo};
        end
        if (!s_r.op_flash || s_r.idx == nac_pkg::LATCH_W'(nac_pkg::LATCH_COUNT - 1)) begin
          s_nxt.st = nac_pkg::ST_WAIT;
        end else begin
          s_nxt.idx = s_r.idx + 1'b1;
        end
      end
      nac_pkg::ST_WAIT: begin
        // self-timed cycle, processor held while flash is busy
        if (s_r.cnt == CNT_W'(PROG_CYCLES - 1)) begin
          s_nxt.wr    = 1'b0;
          s_nxt.err   = 1'b0;
          s_nxt.stall = 1'b0;
          s_nxt.st    = nac_pkg::ST_IDLE;
          if (s_r.op_flash && s_r.op_erase) begin
            s_nxt.erase_sel = 1'b0;
          end
          if (s_r.op_flash && !s_r.op_erase) begin
            s_nxt.latch = {nac_pkg::LATCH_COUNT{nac_pkg::LATCH_ERASED}};
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      default: begin
        s_nxt.st = nac_pkg::ST_IDLE;
      end
    endcase

    // register writes and key tracking take effect at the answering edge
    if (bus_acc) begin
      if (!(pwrite && rid == RID_KEY)) begin
        s_nxt.key = nac_pkg::KEY_NONE;
      end
      if (pwrite) begin
        case (rid)
          RID_DLO: s_nxt.data_lo = pwdata[7:0];
          RID_DHI: s_nxt.data_hi = pwdata[5:0];
          RID_ALO: s_nxt.adr_lo  = pwdata[7:0];
          RID_AHI: s_nxt.adr_hi  = pwdata[6:0];
          RID_KEY: begin
            if (pwdata[7:0] == nac_pkg::KEY_FIRST) begin
              s_nxt.key = nac_pkg::KEY_HALF;
            end else if (s_r.key == nac_pkg::KEY_HALF &&
                         pwdata[7:0] == nac_pkg::KEY_SECOND) begin
              s_nxt.key = nac_pkg::KEY_ARMED;
            end else begin
              s_nxt.key = nac_pkg::KEY_NONE;
            end
          end
          RID_CTL: begin
            // control is frozen while an operation runs
            if (s_r.st == nac_pkg::ST_IDLE) begin
              s_nxt.mem_sel   = pwdata[nac_pkg::BIT_MEM_SEL];
              s_nxt.cfg_sel   = pwdata[nac_pkg::BIT_CFG_SEL];
              s_nxt.llo       = pwdata[nac_pkg::BIT_LLO];
              s_nxt.erase_sel = pwdata[nac_pkg::BIT_ERASE];
              s_nxt.err       = pwdata[nac_pkg::BIT_ERR];
              s_nxt.pen       = pwdata[nac_pkg::BIT_PEN];
              flash_new       = s_nxt.mem_sel | s_nxt.cfg_sel;
              go_ok           = (s_r.key == nac_pkg::KEY_ARMED) && s_nxt.pen &&
                                (!s_nxt.cfg_sel || cfg_ok(adr, 1'b1));
              if (pwdata[nac_pkg::BIT_WR]) begin
                s_nxt.err = 1'b1;
                if (go_ok) begin
                  s_nxt.wr       = 1'b1;
                  s_nxt.op_flash = flash_new;
                  s_nxt.op_erase = s_nxt.erase_sel;
                  s_nxt.idx      = '0;
                  s_nxt.cnt      = '0;
                  s_nxt.mem_cfg  = s_nxt.cfg_sel;
                  s_nxt.mem_flash = flash_new;
                  if (!flash_new) begin
                    s_nxt.st = nac_pkg::ST_ERASE;
                  end else if (s_nxt.erase_sel) begin
                    s_nxt.st    = nac_pkg::ST_ERASE;
                    s_nxt.stall = 1'b1;
                  end else begin
                    s_nxt.latch[s_r.adr_lo[4:0]] = {s_r.data_hi, s_r.data_lo};
                    if (s_nxt.llo) begin
                      s_nxt.wr  = 1'b0;
                      s_nxt.err = 1'b0;
                    end else begin
                      s_nxt.st    = nac_pkg::ST_STREAM;
                      s_nxt.stall = 1'b1;
                    end
                  end
                end
              end else if (pwdata[nac_pkg::BIT_RD]) begin
                s_nxt.rd = 1'b1;
                s_nxt.st = nac_pkg::ST_READ;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r        <= '0;
      s_r.st     <= nac_pkg::ST_IDLE;
      s_r.adr_lo <= nac_pkg::ADR_LO_RST;
      s_r.adr_hi <= nac_pkg::ADR_HI_RST;
      s_r.latch  <= {nac_pkg::LATCH_COUNT{nac_pkg::LATCH_ERASED}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata       = s_r.prdata;
  assign pready       = s_r.pready;
  assign pslverr      = s_r.pslverr;
  assign mem_rd_en    = s_r.mem_rd;
  assign mem_erase_en = s_r.mem_erase;
  assign mem_wr_en    = s_r.mem_wr;
  assign mem_flash    = s_r.mem_flash;
  assign mem_cfg      = s_r.mem_cfg;
  assign mem_addr     = s_r.mem_addr;
  assign mem_wdata    = s_r.mem_wdata;
  assign cpu_stall    = s_r.stall;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_llo_go;
    bus_acc && pwrite && rid == RID_CTL && s_r.st == nac_pkg::ST_IDLE &&
    pwdata[nac_pkg::BIT_WR] && pwdata[nac_pkg::BIT_LLO] &&
    (pwdata[nac_pkg::BIT_MEM_SEL] || pwdata[nac_pkg::BIT_CFG_SEL]);
  endsequence

  sequence s_ee_start;
    $rose(s_r.st == nac_pkg::ST_ERASE) && !s_r.op_flash;
  endsequence

  sequence s_ee_pulses;
    s_r.mem_erase ##1 s_r.mem_wr;
  endsequence

  chk_cfg_read_space: assert property (s_r.mem_rd |-> s_r.mem_cfg == s_r.cfg_sel)
    else $error("config select not passed to array");
  chk_cfg_write_map: assert property ($rose(s_r.wr) && s_r.cfg_sel |-> cfg_ok(adr, 1'b1))
    else $error("write started on read-only config address");
  chk_cfg_bad_clear: assert property ((s_r.st == nac_pkg::ST_READ) && s_r.cfg_sel &&
      !cfg_ok(adr, 1'b0) |=> s_r.data_lo == 8'h00 && s_r.data_hi == 6'h00 && !s_r.mem_rd)
    else $error("bad config read left data");
  chk_mem_target: assert property (s_r.mem_rd |-> s_r.mem_flash == (s_r.mem_sel | s_r.cfg_sel))
    else $error("wrong memory target");
  chk_llo_no_cycle: assert property (s_llo_go |=> (!s_r.wr && !s_r.mem_wr && !s_r.stall)[*3])
    else $error("latch load started a cycle");
  chk_commit_burst: assert property ($rose(s_r.st == nac_pkg::ST_STREAM) && s_r.op_flash
      |=> s_r.mem_wr [*8])
    else $error("latch commit not a burst");
  chk_ee_direct: assert property ($rose(s_r.wr) && !s_r.op_flash |-> s_r.st == nac_pkg::ST_ERASE)
    else $error("eeprom write did not start directly");
  chk_erase_clear: assert property ($fell(s_r.wr) && s_r.op_flash && s_r.op_erase |-> !s_r.erase_sel)
    else $error("erase select not cleared");
  chk_ee_erase_write: assert property (s_ee_start |=> s_ee_pulses)
    else $error("eeprom erase not followed by write");
  chk_err_on_start: assert property ($rose(s_r.wr) |-> s_r.err)
    else $error("error flag not set on write start");
  chk_pen_needed: assert property ($rose(s_r.wr) |-> s_r.pen && $past(s_r.key) == nac_pkg::KEY_ARMED)
    else $error("cycle started without enable or key");
  chk_wr_timed: assert property ($rose(s_r.st == nac_pkg::ST_WAIT) |-> s_r.wr [*8])
    else $error("write bit dropped early");
  chk_rd_one_shot: assert property ($rose(s_r.rd) |-> ##[1:4] !s_r.rd)
    else $error("read bit not cleared");
  chk_hi_addr_one: assert property (s_r.pready && !pwrite && rid == RID_AHI |-> prdata[7])
    else $error("address high top bit not one");
  chk_stall_flash: assert property (s_r.stall |-> s_r.op_flash && s_r.wr)
    else $error("stall outside a flash cycle");
  chk_full_block: assert property ($rose(s_r.st == nac_pkg::ST_WAIT) && s_r.op_flash &&
      !s_r.op_erase |-> $past(s_r.idx) == 5'h1F)
    else $error("latch block not fully written");

endmodule : nac_ctrl

// ==== inc/nac_pkg.sv ====
// Purpose: shared constants and types of the nonvolatile access control block
// Assumes: pclk at 125 MHz, 8-bit APB byte address, 32-bit APB data
// Notes: state codes are one-hot; the latch block is 32 words of 14 bits
package nac_pkg;

  // register byte offsets
  localparam logic [7:0]  OFF_DATA_LO    = 8'h00;
  localparam logic [7:0]  OFF_DATA_HI    = 8'h04;
  localparam logic [7:0]  OFF_ADR_LO     = 8'h08;
  localparam logic [7:0]  OFF_ADR_HI     = 8'h0C;
  localparam logic [7:0]  OFF_CTL        = 8'h10;
  localparam logic [7:0]  OFF_KEY        = 8'h14;

  // control register field positions
  localparam int          BIT_MEM_SEL    = 7;
  localparam int          BIT_CFG_SEL    = 6;
  localparam int          BIT_LLO        = 5;
  localparam int          BIT_ERASE      = 4;
  localparam int          BIT_ERR        = 3;
  localparam int          BIT_PEN        = 2;
  localparam int          BIT_WR         = 1;
  localparam int          BIT_RD         = 0;

  // unlock key sequence and its tracker
  localparam logic [7:0]  KEY_FIRST      = 8'h55;
  localparam logic [7:0]  KEY_SECOND     = 8'hAA;
  localparam logic [1:0]  KEY_NONE       = 2'h0;
  localparam logic [1:0]  KEY_HALF       = 2'h1;
  localparam logic [1:0]  KEY_ARMED      = 2'h2;

  // configuration space map
  localparam logic [15:0] CFG_UID_FIRST  = 16'h8000;
  localparam logic [15:0] CFG_UID_LAST   = 16'h8003;
  localparam logic [15:0] CFG_DEVID      = 16'h8006;
  localparam logic [15:0] CFG_WORD_FIRST = 16'h8007;
  localparam logic [15:0] CFG_WORD_LAST  = 16'h8008;

  // values after reset
  localparam logic [7:0]  ADR_LO_RST     = 8'h00;
  localparam logic [6:0]  ADR_HI_RST     = 7'h00;
  localparam logic [7:0]  DATA_RST       = 8'h00;
  localparam logic [13:0] LATCH_ERASED   = 14'h3FFF;

  // latch block and timing
  localparam int          LATCH_COUNT    = 32;
  localparam int          LATCH_W        = 5;
  localparam int          PROG_TIME_US   = 2000;
  localparam int          CLK_MHZ        = 125;
  localparam int          PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_READ   = 6'h02,
    ST_RCAP   = 6'h04,
    ST_ERASE  = 6'h08,
    ST_STREAM = 6'h10,
    ST_WAIT   = 6'h20
  } nac_state_t;

endpackage : nac_pkg

// ==== verification/nac_mem_model.sv ====
// Purpose: behavioural flash and eeprom array behind the access block
// Assumes: strobes sampled on pclk; read data valid one cycle after
// Notes: unwritten words read erased; idle data lines toggle
module nac_mem_model (
  input  wire logic        pclk,
  input  wire logic        mem_rd_en,
  input  wire logic        mem_erase_en,
  input  wire logic        mem_wr_en,
  input  wire logic        mem_flash,
  input  wire logic        mem_cfg,
  input  wire logic [14:0] mem_addr,
  input  wire logic [13:0] mem_wdata,
  output logic      [13:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [logic [16:0]];
  logic [16:0] k;
  assign k = {mem_cfg, mem_flash | mem_cfg, mem_addr};
  initial mem_rdata = 14'h0000;
  // array: data holds one cycle after a read, then the lines toggle
  always @(posedge pclk) begin
    if (mem_rd_en)
      mem_rdata <= mem.exists(k) ? mem[k] : 14'h3FFF;
    else
      mem_rdata <= ~mem_rdata;
    if (mem_erase_en && (mem_flash || mem_cfg))
      for (int i = 0; i < 32; i++)
        mem[{k[16:5], i[4:0]}] = 14'h3FFF;
    else if (mem_erase_en)
      mem[k] = 14'h3FFF;
    if (mem_wr_en)
      mem[k] = mem_wdata;
  end
endmodule : nac_mem_model

// ==== verification/testbench.sv ====
// Purpose: self-checking bench of the nonvolatile access control block
// Assumes: apb master on pclk, short program time parameter
// Notes: every scenario is its own task
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rd_en, er_en, wr_en, flash, cfg, cpu_stall, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [14:0] maddr;
  logic [13:0] wdata, rdata;
  int fail_count = 0;
  int n_compared = 0;
  nac_ctrl #(.PROG_CYCLES(20), .CNT_W(18)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_rd_en(rd_en), .mem_erase_en(er_en),
    .mem_wr_en(wr_en), .mem_flash(flash), .mem_cfg(cfg), .mem_addr(maddr),
    .mem_wdata(wdata), .mem_rdata(rdata), .cpu_stall(cpu_stall));
  nac_mem_model mem (.pclk(pclk), .mem_rd_en(rd_en), .mem_erase_en(er_en), .mem_wr_en(wr_en),
    .mem_flash(flash), .mem_cfg(cfg), .mem_addr(maddr), .mem_wdata(wdata), .mem_rdata(rdata));
  // clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task test_done;
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // one apb transfer; pready, read data and error are taken at the rising edge that ends it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t bus timeout", $time);
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(q, exp);
  endtask : rd
  task start(input logic [7:0] c);
    wr(nac_pkg::OFF_KEY, 32'h0000_0055);
    wr(nac_pkg::OFF_KEY, 32'h0000_00AA);
    wr(nac_pkg::OFF_CTL, {24'h00_0000, c});
  endtask : start
  task wait_idle;
    int i;
    i = 0;
    do begin
      apb(1'b0, nac_pkg::OFF_CTL, 32'h0000_0000);
      i++;
    end while (q[1:0] !== 2'b00 && i < 100);
    cmp({30'h0, q[1:0]}, 32'h0000_0000);
  endtask : wait_idle
  task read_word(input logic [7:0] c, input logic [7:0] a, input logic [13:0] x);
    wr(nac_pkg::OFF_ADR_LO, {24'h00_0000, a});
    wr(nac_pkg::OFF_CTL, {24'h00_0000, c});
    wait_idle();
    rd(nac_pkg::OFF_DATA_HI, {26'h0, x[13:8]});
    rd(nac_pkg::OFF_DATA_LO, {24'h00_0000, x[7:0]});
  endtask : read_word
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(nac_pkg::OFF_ADR_HI, 32'h0000_0080);
    rd(nac_pkg::OFF_CTL, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    cmp({31'h0, e}, 32'h0000_0001);
    wr(nac_pkg::OFF_DATA_HI, 32'h0000_00FF);
    rd(nac_pkg::OFF_DATA_HI, 32'h0000_003F);
    wr(nac_pkg::OFF_ADR_HI, 32'h0000_007F);
    rd(nac_pkg::OFF_ADR_HI, 32'h0000_00FF);
  endtask : t_regs
  // eeprom write with latch-only and erase set, then key broken and enable off
  task t_eeprom;
    wr(nac_pkg::OFF_ADR_HI, 32'h0000_0000);
    wr(nac_pkg::OFF_ADR_LO, 32'h0000_0012);
    wr(nac_pkg::OFF_DATA_LO, 32'h0000_005A);
    start(8'h36);
    wait_idle();
    cmp(q & 32'h0000_000E, 32'h0000_0004);
    wr(nac_pkg::OFF_DATA_LO, 32'h0000_0000);
    wr(nac_pkg::OFF_CTL, 32'h0000_0001);
    wait_idle();
    rd(nac_pkg::OFF_DATA_LO, 32'h0000_005A);
    wr(nac_pkg::OFF_KEY, 32'h0000_0055);
    wr(nac_pkg::OFF_KEY, 32'h0000_00AA);
    rd(nac_pkg::OFF_DATA_LO, 32'h0000_005A);
    wr(nac_pkg::OFF_CTL, 32'h0000_0006);
    rd(nac_pkg::OFF_CTL, 32'h0000_000C);
    start(8'h02);
    rd(nac_pkg::OFF_CTL, 32'h0000_0008);
  endtask : t_eeprom
  // two latch loads, program, row checks, then a row erase
  task t_flash;
    int i;
    wr(nac_pkg::OFF_ADR_HI, 32'h0000_0001);
    wr(nac_pkg::OFF_ADR_LO, 32'h0000_0040);
    wr(nac_pkg::OFF_DATA_HI, 32'h0000_0012);
    wr(nac_pkg::OFF_DATA_LO, 32'h0000_0034);
    start(8'hA6);
    rd(nac_pkg::OFF_CTL, 32'h0000_00A4);
    wr(nac_pkg::OFF_ADR_LO, 32'h0000_0041);
    wr(nac_pkg::OFF_DATA_HI, 32'h0000_002B);
    wr(nac_pkg::OFF_DATA_LO, 32'h0000_00CD);
    start(8'h86);
    i = 0;
    while (cpu_stall !== 1'b1 && i < 40) begin
      @(negedge pclk);
      i++;
    end
    cmp({31'h0, cpu_stall}, 32'h0000_0001);
    wait_idle();
    cmp(q & 32'h0000_000E, 32'h0000_0004);
    read_word(8'h81, 8'h40, 14'h1234);
    read_word(8'h81, 8'h41, 14'h2BCD);
    read_word(8'h81, 8'h5F, 14'h3FFF);
    wr(nac_pkg::OFF_ADR_LO, 32'h0000_0045);
    start(8'h96);
    wait_idle();
    cmp(q & 32'h0000_001E, 32'h0000_0004);
    read_word(8'h81, 8'h41, 14'h3FFF);
  endtask : t_flash
  // config space: bad read clears data, user id written, device id refused
  task t_cfg;
    wr(nac_pkg::OFF_ADR_HI, 32'h0000_0000);
    read_word(8'h41, 8'h05, 14'h0000);
    wr(nac_pkg::OFF_DATA_HI, 32'h0000_000A);
    wr(nac_pkg::OFF_DATA_LO, 32'h0000_00BC);
    wr(nac_pkg::OFF_ADR_LO, 32'h0000_0001);
    start(8'h46);
    wait_idle();
    read_word(8'h41, 8'h01, 14'h0ABC);
    read_word(8'h81, 8'h01, 14'h3FFF);
    start(8'h46);
    wait_idle();
    wr(nac_pkg::OFF_ADR_LO, 32'h0000_0006);
    start(8'h46);
    rd(nac_pkg::OFF_CTL, 32'h0000_004C);
  endtask : t_cfg
  ////////////////////////////////////////////////////////////////////////////
  // reset, then the scenarios in turn
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_eeprom();
    t_flash();
    t_cfg();
    test_done();
  end
endmodule : testbench
